// ---- core/csc_ctrl.sv ----
// chip select controller: bank decode, selects, write strobes, ack
// assumes request fields synchronous to clk and stable while busy
`timescale 1ns/1ps

// Behaviour
// - drive eight bank selects, four write strobes
// - selects work for core and external masters
// - upper pins carry configured function only
// - strobe 0 is lanes 31..24, onward down
// - strobes only on writes, decoded from size
// - byte write to 8-bit port: strobe 0
// - word to 32-bit port: pair by bit 1
// - address only on pins set as address
// - usable bank size follows address line count
// - core transfers: drive and step address
// - external master transfers: address not driven
// - port widths 8, 16, 32 on upper lanes
// - acknowledge driven after waits for externals
// - per bank base, mask and control
// - masking gives 64 KB to 4 GB blocks
// - bank 0 global select after reset
// - bank 1 may assert on CPU space
// - unmatched space uses default control
// - zero to fifteen wait states
// - banks first, lowest number wins, then DRAM, then default
// - external acknowledge ends core transfer early
// - burst only when enabled and operand wider
module csc_ctrl
    import csc_pkg::*;
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // register port
    input  wire logic [CSC_RADDR_W-1:0] regAddr,
    input  wire logic [CSC_RDATA_W-1:0] regWdata,
    input  wire logic                   regWr,
    input  wire logic                   regRd,
    output logic      [CSC_RDATA_W-1:0] regRdata,
    // transfer request and completion
    input  wire csc_xfer_t              req,
    output logic                        coreAck,
    output logic                        xferEnd,
    output logic                        busy,
    // memory side pins
    output logic      [3:0]             csLowN,
    output logic      [3:0]             upperPin,
    output logic      [3:0]             upperOe,
    output logic      [23:0]            addrOut,
    output logic                        addrOe,
    output logic      [3:0]             dataLaneEn,
    input  wire logic                   transferDoneAckNIn,
    output logic                        transferDoneAckNOut,
    output logic                        transferDoneAckNOe
);

    logic [CSC_CMP_W-1:0] bankBase [CSC_BANKS];
    logic [CSC_CMP_W-1:0] bankMask [CSC_BANKS];
    csc_ctrl_t            bankCtrl [CSC_BANKS];
    csc_ctrl_t            defCtrl;
    logic [3:0]           pinSel;
    logic                 globalBoot;

    csc_state_t           state;
    csc_ctrl_t            actCtrl;
    logic [2:0]           actBank;
    logic                 actHit;
    logic                 actExt;
    logic                 actWrite;
    logic [1:0]           actSize;
    logic [31:0]          curAddr;
    logic [4:0]           beatsLeft;
    logic [3:0]           waitCnt;
    logic [7:0]           selN;
    logic [3:0]           weN;

    logic                 matchHit;
    logic [2:0]           matchIdx;
    csc_ctrl_t            selCtrl;
    logic                 waitDone;
    logic                 beatEnd;
    logic [7:0]           pinFn;
    logic [4:0]           addrLines;

    // log2 of bytes in operand and in port
    function automatic logic [2:0] opLog(input logic [1:0] sz);
        case (sz)
            CSC_SZ_BYTE: opLog = 3'h0;
            CSC_SZ_WORD: opLog = 3'h1;
            CSC_SZ_LONG: opLog = 3'h2;
            default:     opLog = 3'h4;
        endcase
    endfunction : opLog

    function automatic logic [2:0] portLog(input logic [1:0] ps);
        case (ps)
            CSC_PS_8:  portLog = 3'h0;
            CSC_PS_16: portLog = 3'h1;
            default:   portLog = 3'h2;
        endcase
    endfunction : portLog

    // active lanes of one beat; bit 0 is lanes 31..24
    function automatic logic [3:0] laneSel(input logic [1:0] sz,
                                           input logic [1:0] a,
                                           input logic [1:0] ps);
        laneSel = 4'hF;
        case (ps)
            CSC_PS_8:  laneSel = 4'h1;
            CSC_PS_16:
                if (sz == CSC_SZ_BYTE)
                    laneSel = a[0] ? 4'h2 : 4'h1;
                else
                    laneSel = 4'h3;
            default:
                if (sz == CSC_SZ_BYTE)
                    laneSel = 4'(4'h1 << a);
                else if (sz == CSC_SZ_WORD)
                    laneSel = a[1] ? 4'hC : 4'h3;
                else
                    laneSel = 4'hF;
        endcase
    endfunction : laneSel

    // upper pin functions {A27, A26, A25, A24}
    function automatic logic [7:0] pinMap(input logic [3:0] s);
        case (s)
            4'h1:    pinMap = {CSC_FN_WE, CSC_FN_WE, CSC_FN_CS, CSC_FN_CS};
            4'h2:    pinMap = {CSC_FN_WE, CSC_FN_WE, CSC_FN_CS, CSC_FN_AD};
            4'h3:    pinMap = {CSC_FN_WE, CSC_FN_WE, CSC_FN_AD, CSC_FN_AD};
            4'h4:    pinMap = {CSC_FN_WE, CSC_FN_CS, CSC_FN_CS, CSC_FN_CS};
            4'h5:    pinMap = {CSC_FN_WE, CSC_FN_CS, CSC_FN_CS, CSC_FN_AD};
            4'h6:    pinMap = {CSC_FN_WE, CSC_FN_CS, CSC_FN_AD, CSC_FN_AD};
            4'h7:    pinMap = {CSC_FN_WE, CSC_FN_AD, CSC_FN_AD, CSC_FN_AD};
            4'h8:    pinMap = {CSC_FN_CS, CSC_FN_CS, CSC_FN_CS, CSC_FN_CS};
            4'h9:    pinMap = {CSC_FN_CS, CSC_FN_CS, CSC_FN_CS, CSC_FN_AD};
            4'hA:    pinMap = {CSC_FN_CS, CSC_FN_CS, CSC_FN_AD, CSC_FN_AD};
            4'hB:    pinMap = {CSC_FN_CS, CSC_FN_AD, CSC_FN_AD, CSC_FN_AD};
            4'hC:    pinMap = {CSC_FN_AD, CSC_FN_AD, CSC_FN_AD, CSC_FN_AD};
            default: pinMap = {CSC_FN_WE, CSC_FN_WE, CSC_FN_WE, CSC_FN_WE};
        endcase
    endfunction : pinMap

    // register writes
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < CSC_BANKS; i++)
            begin
                bankBase[i] <= '0;
                bankMask[i] <= '0;
                bankCtrl[i] <= CSC_CTRL_RST;
            end
            defCtrl    <= CSC_CTRL_RST;
            pinSel     <= 4'h0;
            globalBoot <= 1'b1;
        end
        else if (regWr)
        begin
            for (int i = 0; i < CSC_BANKS; i++)
            begin
                if (regAddr == CSC_OFF_BASE + 8'(4 * i))
                    bankBase[i] <= regWdata[CSC_CMP_W-1:0];
                if (regAddr == CSC_OFF_MASK + 8'(4 * i))
                    bankMask[i] <= regWdata[CSC_CMP_W-1:0];
                if (regAddr == CSC_OFF_CTRL + 8'(4 * i))
                    bankCtrl[i] <= csc_ctrl_t'(regWdata[CSC_CTRL_W-1:0]);
            end
            // global boot select ends once bank 0 mask is set
            if (regAddr == CSC_OFF_MASK)
                globalBoot <= 1'b0;
            if (regAddr == CSC_OFF_DEF)
                defCtrl <= csc_ctrl_t'(regWdata[CSC_CTRL_W-1:0]);
            if (regAddr == CSC_OFF_PIN)
                pinSel <= regWdata[3:0];
        end
    end

    assign pinFn = pinMap(pinSel);

    // address lines present bound the usable bank size
    always_comb
    begin
        addrLines = 5'(CSC_DED_ADDR);
        for (int j = 0; j < 4; j++)
            if (pinFn[2*j +: 2] == CSC_FN_AD)
                addrLines = addrLines + 5'h01;
    end

    // register reads, unmapped offsets read zero
    always_ff @(posedge clk)
    begin
        if (rst)
            regRdata <= '0;
        else if (regRd)
        begin
            regRdata <= '0;
            for (int i = 0; i < CSC_BANKS; i++)
            begin
                if (regAddr == CSC_OFF_BASE + 8'(4 * i))
                    regRdata <= 32'(bankBase[i]);
                if (regAddr == CSC_OFF_MASK + 8'(4 * i))
                    regRdata <= 32'(bankMask[i]);
                if (regAddr == CSC_OFF_CTRL + 8'(4 * i))
                    regRdata <= 32'(bankCtrl[i]);
            end
            if (regAddr == CSC_OFF_DEF)
                regRdata <= 32'(defCtrl);
            if (regAddr == CSC_OFF_PIN)
                regRdata <= 32'(pinSel);
            if (regAddr == CSC_OFF_STAT)
                regRdata <= 32'({addrLines, globalBoot, actBank, state});
        end
    end

    // first matching bank wins; loop runs downward so bank 0 is last
    always_comb
    begin
        matchHit = 1'b0;
        matchIdx = 3'h0;
        for (int i = CSC_BANKS - 1; i >= 0; i--)
        begin
            if (i == 0 && globalBoot)
            begin
                if (!req.cpuSpace)
                begin
                    matchHit = 1'b1;
                    matchIdx = 3'h0;
                end
            end
            else if (req.cpuSpace)
            begin
                if (i == 1 && bankCtrl[1].cpuSpace)
                begin
                    matchHit = 1'b1;
                    matchIdx = 3'h1;
                end
            end
            else if (((req.addr[31:CSC_CMP_LO] ^ bankBase[i])
                      & ~bankMask[i]) == '0)
            begin
                matchHit = 1'b1;
                matchIdx = 3'(i);
            end
        end
        selCtrl = matchHit ? bankCtrl[matchIdx] : defCtrl;
    end

    assign waitDone = (waitCnt == actCtrl.waits);

    always_comb
    begin
        if (actExt)
            beatEnd = actCtrl.extAck ? waitDone : !transferDoneAckNIn;
        else
            beatEnd = !transferDoneAckNIn || (actCtrl.autoAck && waitDone);
    end

    // transfer sequencing
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state     <= ST_IDLE;
            actCtrl   <= CSC_CTRL_RST;
            actBank   <= 3'h0;
            actHit    <= 1'b0;
            actExt    <= 1'b0;
            actWrite  <= 1'b0;
            actSize   <= CSC_SZ_LONG;
            curAddr   <= '0;
            beatsLeft <= '0;
            waitCnt   <= '0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                    // dram space is served elsewhere; default comes after it
                    if (req.start && (matchHit || !req.dramHit))
                    begin
                        state    <= ST_ACT;
                        actCtrl  <= selCtrl;
                        actBank  <= matchIdx;
                        actHit   <= matchHit;
                        actExt   <= req.extMaster;
                        actWrite <= req.write;
                        actSize  <= req.xferSizeBits;
                        curAddr  <= req.addr;
                        waitCnt  <= '0;
                        if (opLog(req.xferSizeBits) > portLog(selCtrl.portSize))
                            beatsLeft <= 5'((5'h01 << (opLog(req.xferSizeBits)
                                - portLog(selCtrl.portSize))) - 5'h01);
                        else
                            beatsLeft <= '0;
                    end
                ST_ACT:
                    if (beatEnd)
                    begin
                        waitCnt <= '0;
                        if (beatsLeft == '0)
                            state <= ST_IDLE;
                        else
                        begin
                            beatsLeft <= beatsLeft - 5'h01;
                            curAddr   <= curAddr + 32'(1 << 32'(portLog(
                                actCtrl.portSize)));
                            // single transfers drop the select between beats
                            state <= actCtrl.burst ? ST_ACT : ST_GAP;
                        end
                    end
                    else if (waitCnt != CSC_WAIT_MAX)
                        waitCnt <= waitCnt + 4'h1;
                ST_GAP:
                    state <= ST_ACT;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // pins registered from the sequencer; one cycle behind its state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            selN <= 8'hFF;
            weN  <= 4'hF;
            dataLaneEn <= 4'h0;
        end
        else
        begin
            selN <= 8'hFF;
            weN  <= 4'hF;
            dataLaneEn <= 4'h0;
            if (state == ST_ACT)
            begin
                if (actHit)
                    selN[actBank] <= 1'b0;
                dataLaneEn <= laneSel(actSize, curAddr[1:0],
                                      actCtrl.portSize);
                if (actWrite)
                    weN <= ~laneSel(actSize, curAddr[1:0],
                                    actCtrl.portSize);
            end
        end
    end

    assign csLowN = selN[3:0];

    // shared upper pins, address drive and acknowledge
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            upperPin <= 4'hF;
            upperOe  <= 4'hF;
            addrOut  <= '0;
            addrOe   <= 1'b0;
            transferDoneAckNOut <= 1'b1;
            transferDoneAckNOe  <= 1'b0;
            coreAck  <= 1'b0;
            xferEnd  <= 1'b0;
            busy     <= 1'b0;
        end
        else
        begin
            // external masters bring their own address
            addrOe  <= (state != ST_IDLE) && !actExt;
            addrOut <= curAddr[CSC_DED_ADDR-1:0];
            for (int j = 0; j < 4; j++)
            begin
                case (pinFn[2*j +: 2])
                    CSC_FN_CS:
                    begin
                        upperPin[j] <= (state == ST_ACT && actHit
                                        && actBank == 3'(4 + j)) ? 1'b0 : 1'b1;
                        upperOe[j]  <= 1'b1;
                    end
                    CSC_FN_AD:
                    begin
                        upperPin[j] <= curAddr[CSC_DED_ADDR + j];
                        upperOe[j]  <= (state != ST_IDLE) && !actExt;
                    end
                    default:
                    begin
                        upperPin[j] <= !(state == ST_ACT && actWrite
                            && laneSel(actSize, curAddr[1:0],
                                       actCtrl.portSize)[3 - j]);
                        upperOe[j]  <= 1'b1;
                    end
                endcase
            end
            transferDoneAckNOe  <= (state == ST_ACT) && actExt
                                   && actCtrl.extAck;
            transferDoneAckNOut <= !((state == ST_ACT) && actExt
                                     && actCtrl.extAck && waitDone);
            coreAck <= (state == ST_ACT) && !actExt && beatEnd;
            xferEnd <= (state == ST_ACT) && beatEnd && (beatsLeft == '0);
            busy    <= (state != ST_IDLE);
        end
    end

    property p_idleHigh;
        @(posedge clk) disable iff (rst)
        (state == ST_IDLE) |=> (selN == 8'hFF) && (weN == 4'hF);
    endproperty
    a_idleHigh: assert property (p_idleHigh)
        else $error("select or strobe low while idle");

    property p_readNoStrobe;
        @(posedge clk) disable iff (rst)
        (state == ST_ACT && !actWrite) |=> (weN == 4'hF);
    endproperty
    a_readNoStrobe: assert property (p_readNoStrobe)
        else $error("write strobe on a read");

    property p_byte8;
        @(posedge clk) disable iff (rst)
        (state == ST_ACT && actWrite && actCtrl.portSize == CSC_PS_8)
        |=> (weN == 4'hE);
    endproperty
    a_byte8: assert property (p_byte8)
        else $error("8-bit port write not on strobe 0");

    property p_word32;
        @(posedge clk) disable iff (rst)
        (state == ST_ACT && actWrite && actCtrl.portSize == CSC_PS_32
         && actSize == CSC_SZ_WORD)
        |=> (weN == ($past(curAddr[1]) ? 4'h3 : 4'hC));
    endproperty
    a_word32: assert property (p_word32)
        else $error("word strobes wrong on 32-bit port");

    property p_extNoAddr;
        @(posedge clk) disable iff (rst)
        (state != ST_IDLE && actExt) |=> !addrOe;
    endproperty
    a_extNoAddr: assert property (p_extNoAddr)
        else $error("address driven for external master");

    property p_coreAddr;
        @(posedge clk) disable iff (rst)
        (state == ST_ACT && !actExt)
        |=> addrOe && (addrOut == $past(curAddr[23:0]));
    endproperty
    a_coreAddr: assert property (p_coreAddr)
        else $error("core address not driven");

    property p_earlyAck;
        @(posedge clk) disable iff (rst)
        (state == ST_ACT && !actExt && !transferDoneAckNIn) |=> coreAck;
    endproperty
    a_earlyAck: assert property (p_earlyAck)
        else $error("external acknowledge did not end beat");

    property p_extAck;
        @(posedge clk) disable iff (rst)
        (state == ST_ACT && actExt && actCtrl.extAck && waitDone)
        |=> transferDoneAckNOe && !transferDoneAckNOut;
    endproperty
    a_extAck: assert property (p_extAck)
        else $error("acknowledge not driven after waits");

    property p_global;
        @(posedge clk) disable iff (rst)
        (state == ST_IDLE && globalBoot && req.start && !req.cpuSpace)
        |=> actHit && (actBank == 3'h0) ##1 (selN[0] == 1'b0);
    endproperty
    a_global: assert property (p_global)
        else $error("boot select not global");

endmodule : csc_ctrl

// ---- core/csc_pkg.sv ----
// constants and types shared by the chip select controller
// assumes one clock domain and a plain word-wide register port
package csc_pkg;

    // bank count and register port shape
    localparam int          CSC_BANKS    = 8;
    localparam int          CSC_RADDR_W  = 8;
    localparam int          CSC_RDATA_W  = 32;
    localparam int          CSC_CMP_W    = 16;
    localparam int          CSC_CMP_LO   = 16;
    localparam int          CSC_DED_ADDR = 24;

    // register byte offsets; bank i sits at base + 4*i
    localparam logic [7:0]  CSC_OFF_BASE = 8'h00;
    localparam logic [7:0]  CSC_OFF_MASK = 8'h20;
    localparam logic [7:0]  CSC_OFF_CTRL = 8'h40;
    localparam logic [7:0]  CSC_OFF_DEF  = 8'h60;
    localparam logic [7:0]  CSC_OFF_PIN  = 8'h64;
    localparam logic [7:0]  CSC_OFF_STAT = 8'h68;

    // transfer size codes on xferSizeBits
    localparam logic [1:0]  CSC_SZ_LONG  = 2'h0;
    localparam logic [1:0]  CSC_SZ_BYTE  = 2'h1;
    localparam logic [1:0]  CSC_SZ_WORD  = 2'h2;
    localparam logic [1:0]  CSC_SZ_LINE  = 2'h3;

    // port size codes
    localparam logic [1:0]  CSC_PS_32    = 2'h0;
    localparam logic [1:0]  CSC_PS_8     = 2'h1;
    localparam logic [1:0]  CSC_PS_16    = 2'h2;

    // function of a shared upper pin
    localparam logic [1:0]  CSC_FN_WE    = 2'h0;
    localparam logic [1:0]  CSC_FN_CS    = 2'h1;
    localparam logic [1:0]  CSC_FN_AD    = 2'h2;

    localparam logic [3:0]  CSC_WAIT_MAX = 4'hF;

    // per-space control word, low bits of the control register
    typedef struct packed {
        logic       cpuSpace;
        logic       burst;
        logic       extAck;
        logic       autoAck;
        logic [3:0] waits;
        logic [1:0] portSize;
    } csc_ctrl_t;

    localparam int          CSC_CTRL_W   = $bits(csc_ctrl_t);
    localparam csc_ctrl_t   CSC_CTRL_RST = '{cpuSpace: 1'b0, burst: 1'b0,
        extAck: 1'b0, autoAck: 1'b1, waits: 4'hF, portSize: 2'h0};

    // one bus transfer request from the core or an external master
    typedef struct packed {
        logic        start;
        logic        extMaster;
        logic        write;
        logic        cpuSpace;
        logic        dramHit;
        logic [1:0]  xferSizeBits;
        logic [31:0] addr;
    } csc_xfer_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACT  = 2'b01,
        ST_GAP  = 2'b10
    } csc_state_t;

endpackage : csc_pkg

// ---- verification/chip_select_controller_tb.sv ----
// self-checking bench for the chip select controller
// assumes bank 0 is the global select after reset
`timescale 1ns/1ps
module chip_select_controller_tb;
    import csc_pkg::*;
    typedef struct packed
    {
        logic [1:0] ps; logic wr; logic [1:0] sz; logic [1:0] a;
        logic [3:0] pin;
    } csc_row_t;
    logic        clk, rst, regWr, regRd, coreAck, xferEnd, busy, addrOe;
    logic        ackOut, ackOe, pAckN, pAckOe, ackOn, ackLine;
    logic [7:0]  regAddr;
    logic [31:0] regWdata, regRdata;
    logic [3:0]  csLowN, upperPin, upperOe, dataLaneEn, ackDelay, sel, lanes;
    logic [23:0] addrOut;
    csc_xfer_t   req;
    int          errors, nCompared, cyc;
    bit          sawAddr, sawAck;
    csc_row_t    rows [12] = '{
        '{CSC_PS_32, 1, CSC_SZ_BYTE, 0, 4'h7},
        '{CSC_PS_32, 1, CSC_SZ_BYTE, 1, 4'hB},
        '{CSC_PS_32, 1, CSC_SZ_BYTE, 2, 4'hD},
        '{CSC_PS_32, 1, CSC_SZ_BYTE, 3, 4'hE},
        '{CSC_PS_32, 1, CSC_SZ_WORD, 0, 4'h3},
        '{CSC_PS_32, 1, CSC_SZ_WORD, 2, 4'hC},
        '{CSC_PS_32, 1, CSC_SZ_LONG, 0, 4'h0},
        '{CSC_PS_8, 1, CSC_SZ_BYTE, 1, 4'h7},
        '{CSC_PS_8, 1, CSC_SZ_BYTE, 3, 4'h7},
        '{CSC_PS_16, 1, CSC_SZ_BYTE, 1, 4'hB},
        '{CSC_PS_16, 1, CSC_SZ_BYTE, 2, 4'h7},
        '{CSC_PS_32, 0, CSC_SZ_LONG, 0, 4'hF}};

    // the acknowledge line is pulled up when nobody drives it
    assign ackLine = ackOe ? ackOut : (pAckOe ? pAckN : 1'b1);

    csc_ctrl uut (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .req(req), .coreAck(coreAck),
        .xferEnd(xferEnd), .busy(busy), .csLowN(csLowN),
        .upperPin(upperPin), .upperOe(upperOe), .addrOut(addrOut),
        .addrOe(addrOe), .dataLaneEn(dataLaneEn),
        .transferDoneAckNIn(ackLine), .transferDoneAckNOut(ackOut),
        .transferDoneAckNOe(ackOe));
    csc_mem_model mem (.clk(clk), .csLowN(csLowN), .ackDelay(ackDelay),
        .ackOn(ackOn), .ackN(pAckN), .ackOe(pAckOe));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp)
            $display("Error %0t: got %h expected %h", $time, seen, exp);
        if (seen !== exp)
            errors++;
    endtask : check

    task automatic end_sim;
        if (errors == 0 && nCompared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    task automatic regAcc(input logic wr, input logic [7:0] a,
                          input logic [31:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= wr;
        regRd    <= !wr;
        @(posedge clk);
        regWr <= 1'b0;
        regRd <= 1'b0;
        #1;
    endtask : regAcc

    // one transfer; records the select seen and cycles to its end
    task automatic xfer(input logic ext, wr, cpu, input logic [1:0] sz,
                        input logic [1:0] a, input logic [3:0] pin);
        @(posedge clk);
        req <= '{1'b1, ext, wr, cpu, 1'b0, sz, {30'h0048D000, a}};
        @(posedge clk);
        req.start <= 1'b0;
        {sel, lanes, sawAddr, sawAck, cyc} = {8'hFF, 2'b0, 32'd0};
        while (cyc < 40 && xferEnd !== 1'b1)
        begin
            @(posedge clk);
            #1;
            cyc++;
            if (sel == 4'hF && csLowN !== 4'hF)
                check(upperPin, pin);
            if (sel == 4'hF)
                {sel, lanes} = {csLowN, dataLaneEn};
            sawAddr |= (addrOe === 1'b1);
            sawAck  |= (ackOe === 1'b1 && ackOut === 1'b0);
        end
        // a transfer that never ended is a failure
        if (cyc == 40)
            errors++;
        repeat (2) @(posedge clk);
        #1;
        check({csLowN, upperPin}, 8'hFF);
    endtask : xfer

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        end_sim();
    end

    initial
    begin
        {rst, regWr, regRd, regAddr, regWdata, req} = {1'b1, 81'h0};
        {ackOn, ackDelay, errors, nCompared} = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        check({csLowN, upperPin, upperOe, addrOe, ackOe}, 14'h3FFC);
        regAcc(0, CSC_OFF_CTRL, 0);
        check(regRdata, 32'h7C);
        regAcc(0, 8'hFC, 0);
        check(regRdata, 32'h0);
        foreach (rows[i])
        begin
            regAcc(1, CSC_OFF_CTRL, {24'h0, 6'h10, rows[i].ps});
            xfer(0, rows[i].wr, 0, rows[i].sz, rows[i].a, rows[i].pin);
            check(sel, 4'hE);
            check(cyc, 1);
            check(sawAddr, 1);
        end
        // word on an 8-bit port: two beats, burst then single
        regAcc(1, CSC_OFF_CTRL, 32'h141);
        xfer(0, 1, 0, CSC_SZ_WORD, 0, 4'h7);
        check({sel, lanes}, 8'hE1);
        check(cyc, 2);
        check(addrOut, 24'h234001);
        regAcc(1, CSC_OFF_CTRL, 32'h41);
        xfer(0, 1, 0, CSC_SZ_WORD, 0, 4'h7);
        check(cyc, 3);
        regAcc(1, CSC_OFF_CTRL, 32'h7C);
        xfer(0, 1, 0, CSC_SZ_LONG, 0, 4'h0);
        check(cyc, 16);
        {ackOn, ackDelay} <= {1'b1, 4'h2};
        xfer(0, 1, 0, CSC_SZ_LONG, 0, 4'h0);
        check(cyc, 5);
        ackOn <= 1'b0;
        regAcc(1, CSC_OFF_CTRL, 32'hC8);
        xfer(1, 1, 0, CSC_SZ_LONG, 0, 4'h0);
        check({sawAddr, sawAck}, 2'b01);
        regAcc(1, CSC_OFF_CTRL + 8'h04, 32'h240);
        xfer(0, 0, 1, CSC_SZ_LONG, 0, 4'hF);
        check(sel, 4'hD);
        // end boot select; banks 2 and 3 both match, bank 2 first
        regAcc(1, CSC_OFF_MASK, 0);
        regAcc(1, CSC_OFF_BASE + 8'h0C, 32'h0123);
        regAcc(1, CSC_OFF_MASK + 8'h08, 32'h7FFF);
        xfer(0, 0, 0, CSC_SZ_LONG, 0, 4'hF);
        check(sel, 4'hB);
        regAcc(1, CSC_OFF_MASK + 8'h08, 0);
        xfer(0, 0, 0, CSC_SZ_LONG, 0, 4'hF);
        check(sel, 4'h7);
        // all four upper pins as address: 28 lines
        regAcc(1, CSC_OFF_PIN, 32'hC);
        regAcc(0, CSC_OFF_STAT, 0);
        check(regRdata, 32'h70C);
        end_sim();
    end
endmodule : chip_select_controller_tb

// ---- verification/csc_mem_model.sv ----
// external memory model that acknowledges a selected access
// assumes active-low selects and a pulled-up acknowledge line
`timescale 1ns/1ps
module csc_mem_model
(
    // clock
    input  wire logic       clk,
    // memory side
    input  wire logic [3:0] csLowN,
    input  wire logic [3:0] ackDelay,
    input  wire logic       ackOn,
    output logic            ackN,
    output logic            ackOe
);
    logic [3:0] cnt;

    // one acknowledge pulse per 16 cycles of select, then the line is let go
    always_ff @(posedge clk)
    begin
        if (&csLowN)
        begin
            cnt   <= 4'h0;
            ackOe <= 1'b0;
        end
        else
        begin
            cnt   <= cnt + 4'h1;
            ackOe <= ackOn && (cnt == ackDelay);
        end
    end
    assign ackN = ~ackOe;
endmodule : csc_mem_model
